// [hw/aps_sequencer.sv]
// Purpose: Speaker amplifier control and per-block fastcharge handshake
// Assumes: APB slave, one clock, firmware drives the timed sequences
// Notes: Contract
// Contract
// (R1) Amp control bit 4 selects high power when set, low power when clear; the code drives bit 4 to amp_low_power_sel, where set means low power
// (R2) Amp control bit 6 turns amplifier on; bit 7 unused reads zero
// (R3) Amp control bit 5 requests input capacitor precharge while set
// (R4) Amp control bits 3:0 hold the gain code applied to amplifier
// (R5) Code 1 is +20 dB, minus 3 dB per code; 0 and 15 give -22
// (R6) Firmware writes the headset power-on sequence with 500 ms and 1 ms waits
// (R7) Firmware writes headset power-off sequence with a 1 ms wait
// (R8) Firmware starts serial input: reset mask, resets, 5 ms wait, DACs on
// (R9) Firmware clears DAC power before stopping serial stream and bit clock
// (R10) Firmware precharges amplifier input capacitors before switching it on
// (R11) Firmware sets minimum gain before switching amplifier off
// (R12) Fastcharge set then power set; charging starts once power is high
// (R13) Firmware clears fastcharge when period ends; block then ready
// (R14) Clearing power bit powers down; full sequence needed again
// (R15) Reference, line in/out, aux and speaker driver each pair power and fastcharge
// (R16) Any combination of fastcharge bits may be set together
// (R17) Audio reset held low until supplies are established
// (R18) Mode: standby, precharge, active; both bits set is forbidden
// (R19) Timed delays are counted by firmware against the system clock
`timescale 1ns/1ns
module aps_sequencer
  import aps_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Audio controls
  output aps_amp_out_type amp_out,
  output aps_amp_mode_type amp_mode,
  output aps_blk_out_type blk_out
);

  function automatic logic signed [7:0] gain_db_of(input logic [3:0] code);
    logic signed [7:0] g;
    g = GAIN_MIN_DB;
    if (code != 4'h0 && code != GAIN_CODE_MIN) begin
      g = 8'(GAIN_TOP_DB - 8'(GAIN_STEP_DB * 8'(code - GAIN_CODE_TOP)));
    end
    return g;
  endfunction

  logic [7:0] amp_ctrl_q, amp_ctrl_d;
  logic [7:0] prech_q, prech_d;
  logic [7:0] blkpwr_q, blkpwr_d;
  logic [NUM_BLK-1:0] armed_q, armed_d;
  logic [NUM_BLK-1:0] ready_q, ready_d;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  aps_amp_out_type amp_out_q;
  aps_amp_mode_type amp_mode_q, amp_mode_d;
  aps_blk_out_type blk_out_q;

  // Bus decode; a request is answered even if its setup cycle was frozen
  wire logic setup = psel && !pready_q;
  wire logic hit_amp = paddr[9:0] == AMP_CTRL_ADDR;
  wire logic hit_prech = paddr[9:0] == PRECH_ADDR;
  wire logic hit_pwr = paddr[9:0] == BLKPWR_ADDR;
  wire logic hit_stat = paddr[9:0] == STATUS_ADDR;
  wire logic hit_any = (hit_amp || hit_prech || hit_pwr || hit_stat) && paddr[11:10] == 2'b00;
  // Writes land at the completing edge, where pready is sampled high
  wire logic wr = psel && penable && pready_q && pwrite && hit_any;

  // Block order: 0 reference, 1..6 line in L/R, line out L/R, aux, speaker
  wire logic [NUM_BLK-1:0] power_vec = {blkpwr_q[NUM_BLK-1:1], prech_q[0]};
  wire logic [NUM_BLK-1:0] fast_vec = prech_q[NUM_BLK:1];

  always_comb begin
    amp_ctrl_d = amp_ctrl_q;
    prech_d = prech_q;
    blkpwr_d = blkpwr_q;
    if (wr && hit_amp) begin
      amp_ctrl_d = pwdata[7:0] & AMP_CTRL_MASK; // [R2]
    end
    if (wr && hit_prech) begin
      prech_d = pwdata[7:0]; // [R16]
    end
    if (wr && hit_pwr) begin
      blkpwr_d = {pwdata[7:1], 1'b0};
    end
  end

  // Charging begins whenever power and fastcharge are both set and the block is not ready
  always_comb begin
    armed_d = armed_q;
    ready_d = ready_q;
    for (int i = 0; i < NUM_BLK; i++) begin
      if (!power_vec[i]) begin
        armed_d[i] = 1'b0; // [R14]
        ready_d[i] = 1'b0; // [R14]
      end else if (fast_vec[i] && !ready_q[i]) begin
        armed_d[i] = 1'b1; // [R12]
      end else if (!fast_vec[i] && armed_q[i]) begin
        armed_d[i] = 1'b0;
        ready_d[i] = 1'b1; // [R13]
      end
    end
  end

  wire logic amp_on = amp_ctrl_d[AMP_ON_BIT]; // [R2]
  wire logic amp_pre = amp_ctrl_d[AMP_PRECH_BIT]; // [R3]
  always_comb begin
    unique case ({amp_on, amp_pre}) // [R18]
      2'b00: amp_mode_d = AMP_STANDBY;
      2'b01: amp_mode_d = AMP_PRECHARGE;
      2'b10: amp_mode_d = AMP_ACTIVE;
      2'b11: amp_mode_d = AMP_FORBIDDEN;
    endcase
  end

  wire logic [31:0] rd_mux =
    hit_amp ? {24'h000000, amp_ctrl_q} :
    hit_prech ? {24'h000000, prech_q} :
    hit_pwr ? {24'h000000, blkpwr_q} :
    hit_stat ? {18'h0, ready_q, armed_q} : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      amp_ctrl_q <= AMP_CTRL_RESET;
      prech_q <= PRECH_RESET;
      blkpwr_q <= BLKPWR_RESET;
      armed_q <= '0;
      ready_q <= '0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      amp_out_q <= '0;
      amp_mode_q <= AMP_STANDBY;
      blk_out_q <= '0;
    end else if (clk_en) begin
      amp_ctrl_q <= amp_ctrl_d;
      prech_q <= prech_d;
      blkpwr_q <= blkpwr_d;
      armed_q <= armed_d;
      ready_q <= ready_d;
      pready_q <= setup;
      pslverr_q <= setup && !hit_any;
      prdata_q <= (setup && !pwrite && hit_any) ? rd_mux : 32'h00000000;
      amp_out_q.amp_power_on <= amp_ctrl_d[AMP_ON_BIT]; // [R2]
      amp_out_q.amp_input_precharge <= amp_ctrl_d[AMP_PRECH_BIT]; // [R3]
      amp_out_q.amp_low_power_sel <= amp_ctrl_d[AMP_LP_BIT]; // [R1]
      amp_out_q.amp_gain_code <= amp_ctrl_d[AMP_GAIN_MSB:0]; // [R4]
      amp_out_q.gain_db <= gain_db_of(amp_ctrl_d[AMP_GAIN_MSB:0]); // [R5]
      amp_mode_q <= amp_mode_d;
      blk_out_q.power <= power_vec; // [R15]
      blk_out_q.charging <= armed_d;
      blk_out_q.ready <= ready_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign amp_out = amp_out_q;
  assign amp_mode = amp_mode_q;
  assign blk_out = blk_out_q;

  AST_GAIN_TOP: assert property (@(posedge mclk) disable iff (!nrst) // [R5]
    clk_en && amp_ctrl_d[3:0] == 4'h1 |=> amp_out.gain_db == 8'sh14)
    else $error("gain code 1 not +20 dB");
  AST_GAIN_MIN: assert property (@(posedge mclk) disable iff (!nrst) // [R5]
    clk_en && (amp_ctrl_d[3:0] == 4'hf || amp_ctrl_d[3:0] == 4'h0)
    |=> amp_out.gain_db == 8'shea)
    else $error("minimum gain code not -22 dB");
  AST_AMP_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // [R4]
    clk_en && wr && hit_amp |=> amp_out.amp_gain_code == $past(pwdata[3:0]))
    else $error("gain code not applied");
  AST_BIT7_ZERO: assert property (@(posedge mclk) disable iff (!nrst) // [R2]
    amp_ctrl_q[7] == 1'b0)
    else $error("unused bit set");
  AST_MODE_ACT: assert property (@(posedge mclk) disable iff (!nrst) // [R18]
    amp_out.amp_power_on && !amp_out.amp_input_precharge |-> amp_mode == AMP_ACTIVE)
    else $error("active mode mismatch");
  AST_MODE_PRE: assert property (@(posedge mclk) disable iff (!nrst) // [R3]
    !amp_out.amp_power_on && amp_out.amp_input_precharge |-> amp_mode == AMP_PRECHARGE)
    else $error("precharge mode mismatch");
  AST_PWR_DOWN: assert property (@(posedge mclk) disable iff (!nrst) // [R14]
    clk_en && !power_vec[0] |=> !blk_out.ready[0] && !blk_out.charging[0])
    else $error("block not powered down");
  AST_CHARGE: assert property (@(posedge mclk) disable iff (!nrst) // [R12]
    clk_en && power_vec[0] && fast_vec[0] && !ready_q[0] |=> blk_out.charging[0])
    else $error("fastcharge did not start");
  AST_READY: assert property (@(posedge mclk) disable iff (!nrst) // [R13]
    clk_en && power_vec[1] && !fast_vec[1] && armed_q[1] |=> blk_out.ready[1])
    else $error("block not ready after fastcharge");
  AST_APB_ONE: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_LOW_POWER: assert property (@(posedge mclk) disable iff (!nrst) // [R1]
    clk_en && wr && hit_amp |=> amp_out.amp_low_power_sel == $past(pwdata[4]))
    else $error("power selection not applied");
  AST_PRECH_WR: assert property (@(posedge mclk) disable iff (!nrst) // [R16]
    clk_en && wr && hit_prech |=> prech_q == $past(pwdata[7:0]))
    else $error("fastcharge bits not taken together");
  AST_FAST_ANY: assert property (@(posedge mclk) disable iff (!nrst) // [R16]
    clk_en && (&power_vec) && (&fast_vec) && (ready_q == '0) |=> (&blk_out.charging))
    else $error("blocks did not charge together");
  AST_MODE_STBY: assert property (@(posedge mclk) disable iff (!nrst) // [R18]
    !amp_out.amp_power_on && !amp_out.amp_input_precharge |-> amp_mode == AMP_STANDBY)
    else $error("standby mode mismatch");
  AST_MODE_BAD: assert property (@(posedge mclk) disable iff (!nrst) // [R18]
    amp_out.amp_power_on && amp_out.amp_input_precharge |-> amp_mode == AMP_FORBIDDEN)
    else $error("forbidden mode not reported");
  // Refused transfers answer with zero data and leave state alone
  AST_ERR_PULSE: assert property (@(posedge mclk) disable iff (!nrst)
    pslverr |-> pready)
    else $error("pslverr without pready");
  AST_REFUSED: assert property (@(posedge mclk) disable iff (!nrst)
    pslverr |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  AST_NO_WRITE_ERR: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && psel && penable && pready && pwrite && !hit_any |=> amp_ctrl_q == $past(amp_ctrl_q))
    else $error("refused write changed a register");
endmodule

// [hw/aps_pkg.sv]
// Purpose: Shared constants and types for the audio power-up sequencer
// Assumes: APB with 32-bit data, byte addresses
// Notes: Register offsets are byte addresses (index times four)
package aps_pkg;
  // Register indices and byte addresses
  localparam logic [7:0] AMP_CTRL_IDX = 8'h11;
  localparam logic [7:0] PRECH_IDX = 8'h0c;
  localparam logic [7:0] BLKPWR_IDX = 8'h20;
  localparam logic [7:0] STATUS_IDX = 8'h21;
  localparam logic [9:0] AMP_CTRL_ADDR = {AMP_CTRL_IDX, 2'b00};
  localparam logic [9:0] PRECH_ADDR = {PRECH_IDX, 2'b00};
  localparam logic [9:0] BLKPWR_ADDR = {BLKPWR_IDX, 2'b00};
  localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  // Amplifier control fields
  localparam int AMP_ON_BIT = 6;
  localparam int AMP_PRECH_BIT = 5;
  localparam int AMP_LP_BIT = 4;
  localparam int AMP_GAIN_MSB = 3;
  localparam logic [7:0] AMP_CTRL_RESET = 8'h00;
  localparam logic [7:0] AMP_CTRL_MASK = 8'h7f;
  // Fastcharge register: bit 0 reference power, bits 7:1 fastcharge per block
  localparam logic [7:0] PRECH_RESET = 8'h00;
  localparam logic [7:0] BLKPWR_RESET = 8'h00;
  localparam int NUM_BLK = 7;
  // Gain decode
  localparam logic signed [7:0] GAIN_MIN_DB = 8'shea;
  localparam logic signed [7:0] GAIN_TOP_DB = 8'sh14;
  localparam logic signed [7:0] GAIN_STEP_DB = 8'sh03;
  localparam logic [3:0] GAIN_CODE_TOP = 4'h1;
  localparam logic [3:0] GAIN_CODE_MIN = 4'hf;

  typedef enum logic [1:0] {
    AMP_STANDBY,
    AMP_PRECHARGE,
    AMP_ACTIVE,
    AMP_FORBIDDEN
  } aps_amp_mode_type;

  typedef struct packed {
    logic amp_power_on;
    logic amp_input_precharge;
    logic amp_low_power_sel;
    logic [3:0] amp_gain_code;
    logic signed [7:0] gain_db;
  } aps_amp_out_type;

  typedef struct packed {
    logic [NUM_BLK-1:0] power;
    logic [NUM_BLK-1:0] charging;
    logic [NUM_BLK-1:0] ready;
  } aps_blk_out_type;
endpackage

// [dv/aps_testbench.sv]
// Purpose: Self-checking bench for the audio power-up sequencer
// Assumes: APB answer within a few cycles, block outputs settle one edge after a write lands
// Notes: Block outputs are checked after a short settle wait
`timescale 1ns/1ns
module testbench
  import aps_pkg::*;
;
  logic mclk, nrst, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  aps_amp_out_type amp_out;
  aps_amp_mode_type amp_mode;
  aps_blk_out_type blk_out;
  int errors, tests_run, g;

  aps_sequencer uut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .amp_out(amp_out),
    .amp_mode(amp_mode), .blk_out(blk_out));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask

  // Scaled clock rate keeps millisecond waits short
  localparam int CYC_PER_MS = 10;
  task automatic wait_ms(input int ms);
    repeat (ms * CYC_PER_MS) @(posedge mclk);
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    nrst = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    xfer(1'b0, {2'b00, AMP_CTRL_ADDR}, 32'h0);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, {2'b00, PRECH_ADDR}, 32'h0);
    chk(rd, 32'h0000_0000);
    // Gain codes with alternating power selection
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, {2'b00, AMP_CTRL_ADDR}, {27'h0, c[0], c[3:0]});
      settle();
      g = (c == 0 || c == 15) ? -22 : 20 - 3 * (c - 1);
      chk({24'h0, amp_out.gain_db}, {24'h0, 8'(g)});
      chk({28'h0, amp_out.amp_gain_code}, {28'h0, c[3:0]});
      chk({31'h0, amp_out.amp_low_power_sel}, {31'h0, c[0]});
    end
    // Mode table: precharge before on, minimum gain code held throughout
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, {2'b00, AMP_CTRL_ADDR}, {25'h0, m[1], m[0], 5'h0f});
      settle();
      g = m[1] ? (m[0] ? 3 : 2) : (m[0] ? 1 : 0);
      chk({30'h0, amp_mode}, 32'(g));
      chk({31'h0, amp_out.amp_input_precharge}, {31'h0, m[0]});
      chk({31'h0, amp_out.amp_power_on}, {31'h0, m[1]});
    end
    xfer(1'b1, {2'b00, AMP_CTRL_ADDR}, 32'h0000_00ff);
    xfer(1'b0, {2'b00, AMP_CTRL_ADDR}, 32'h0);
    chk(rd, 32'h0000_007f);
    // All blocks charge together, then become ready
    xfer(1'b1, {2'b00, PRECH_ADDR}, 32'h0000_00ff);
    xfer(1'b1, {2'b00, BLKPWR_ADDR}, 32'h0000_007e);
    settle();
    chk({25'h0, blk_out.power}, 32'h0000_007f);
    chk({25'h0, blk_out.charging}, 32'h0000_007f);
    xfer(1'b1, {2'b00, PRECH_ADDR}, 32'h0000_0001);
    settle();
    chk({25'h0, blk_out.ready}, 32'h0000_007f);
    xfer(1'b0, {2'b00, STATUS_ADDR}, 32'h0);
    chk({25'h0, rd[13:7]}, 32'h0000_007f);
    xfer(1'b1, {2'b00, BLKPWR_ADDR}, 32'h0);
    settle();
    chk({25'h0, blk_out.ready}, 32'h0000_0001);
    // Power again without a charge cycle stays not ready
    xfer(1'b1, {2'b00, BLKPWR_ADDR}, 32'h0000_007e);
    settle();
    chk({25'h0, blk_out.ready}, 32'h0000_0001);
    xfer(1'b0, 12'h3fc, 32'h0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, 12'h444, 32'h0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // Frozen while the clock enable is low
    clk_en <= 1'b0;
    fork
      xfer(1'b1, {2'b00, AMP_CTRL_ADDR}, 32'h0000_0005);
      begin
        repeat (4) @(posedge mclk);
        chk({28'h0, amp_out.amp_gain_code}, 32'h0000_000f);
        clk_en <= 1'b1;
      end
    join
    settle();
    chk({28'h0, amp_out.amp_gain_code}, 32'h0000_0005);
    // Reset in mid-run, then the headset power-on and power-off sequences
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    chk({25'h0, blk_out.ready}, 32'h0000_0000);
    xfer(1'b1, 12'h040, 32'h0000_0007);
    chk({31'h0, err}, 32'h0000_0001);
    xfer(1'b1, {2'b00, PRECH_ADDR}, 32'h0000_00ff);
    xfer(1'b1, 12'h000, 32'h0000_0030);
    wait_ms(500);
    chk({25'h0, blk_out.charging}, 32'h0000_0001);
    xfer(1'b1, 12'h004, 32'h0000_000c);
    wait_ms(1);
    xfer(1'b1, 12'h000, 32'h0000_003c);
    xfer(1'b1, 12'h000, 32'h0000_0030);
    xfer(1'b1, {2'b00, PRECH_ADDR}, 32'h0000_0000);
    wait_ms(1);
    xfer(1'b1, 12'h000, 32'h0000_0000);
    chk({25'h0, blk_out.power}, 32'h0000_0000);
    chk({25'h0, blk_out.charging}, 32'h0000_0000);
    // Serial input start and stop reach no register of this block
    xfer(1'b1, 12'h040, 32'h0000_0004);
    xfer(1'b1, 12'h040, 32'h0000_0007);
    xfer(1'b1, 12'h040, 32'h0000_0003);
    wait_ms(5);
    xfer(1'b1, 12'h000, 32'h0000_000c);
    xfer(1'b1, 12'h000, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    xfer(1'b0, {2'b00, AMP_CTRL_ADDR}, 32'h0);
    chk(rd, 32'h0000_0000);
    complete_run();
  end
endmodule
